// ---- hdl/dlia_pkg.sv ----
// constants, field layouts and carriers for the dual link interrupt aggregator
// assumes a single 100 MHz clock and a synchronous 9-bit address / 8-bit data register port
// Notes on behaviour
// - interrupt output low while any enabled condition is pending, released when none remains.
// - timer interrupts only when second_tick_flag and second_tick_enable are both set.
// - link request field shows which of the two links has a pending interrupt.
// - each module indication bit reads 1 exactly while its function block has pending interrupts.
// - first module register: framing block flags; in-band and bit message only in T1/J1.
// - second module register: three tx, three rx link controllers, elastic store, system interface.
// - third module register flags pending interrupts of the line interface unit.
// - a leaf indication reaches the output only when its own enable is set.
package dlia_pkg;
	localparam int           NLINK        = 2;
	localparam int           NSRC         = 17;       // function blocks per link
	localparam int           LEAF_W       = 8;        // leaf indications per function block
	localparam int           AW           = 9;
	localparam int           DW           = 8;
	// register offsets; link 1 copies sit at LINK_STRIDE above link 0
	localparam logic [AW-1:0] ADDR_LINK_REQ  = 9'h009;
	localparam logic [AW-1:0] ADDR_TICK_CTRL = 9'h00a;
	localparam logic [AW-1:0] ADDR_TICK_FLAG = 9'h00b;
	localparam logic [AW-1:0] ADDR_MOD_LINE  = 9'h03f;
	localparam logic [AW-1:0] ADDR_MOD_FRM   = 9'h040;
	localparam logic [AW-1:0] ADDR_MOD_HDLC  = 9'h041;
	localparam logic [AW-1:0] LINK_STRIDE    = 9'h100;
	// field positions
	localparam int           LINK_REQ_LSB   = 1;      // link_request_bits at [2:1]
	localparam int           TICK_BIT       = 0;      // second_tick_flag / second_tick_enable
	localparam int           SRC_MOD1_BASE  = 8;      // sources 8..15 map to second module register
	localparam int           SRC_LINE       = 16;     // line_unit_flag, in the third register
	localparam int           LINE_BIT       = 0;      // line_unit_flag position in the third register
	localparam int           SRC_INBAND     = 7;      // inband_code_flag, T1/J1 only
	localparam int           SRC_BITMSG     = 6;      // bit_message_flag, T1/J1 only
	localparam logic [DW-1:0] TICK_CTRL_RST = 8'h00;
	// one-second timer
	localparam longint       CLK_HZ         = 100_000_000;
	localparam longint       TICK_PERIOD_S  = 1;
	localparam longint       TICK_CYCLES    = CLK_HZ * TICK_PERIOD_S;
	localparam int           TICK_CW        = 27;

	// leaf indications and their enables of one link
	typedef struct packed {
		logic [NSRC-1:0][LEAF_W-1:0] ind;
		logic [NSRC-1:0][LEAF_W-1:0] en;
	} dlia_leaf_s;

	// register port request
	typedef struct packed {
		logic          rd;
		logic          wr;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
	} dlia_req_s;
endpackage

// ---- hdl/dlia_top.sv ----
// dual link interrupt aggregator: leaf events to module flags, link request and the interrupt pin
// assumes synchronous inputs, leaf indications held by their blocks until the host serves them
`timescale 1ns/100ps
module dlia_top import dlia_pkg::*; #(
	parameter longint TICK_DIV = TICK_CYCLES       // shorten in simulation
) (
	input  wire logic            mclk_i,           // system clock
	input  wire logic            srst_i,           // synchronous reset, active high
	input  wire dlia_leaf_s      leaf_i [NLINK],   // per link leaf indications and enables
	input  wire logic [NLINK-1:0] t1_mode_i,       // per link, high in T1/J1 mode
	input  wire dlia_req_s       req_i,            // register access
	output logic [DW-1:0]        rdata_o,          // read data, one cycle after rd
	output logic                 int_n_o           // interrupt, active low
);
	logic [NLINK-1:0][NSRC-1:0] mod_flag;
	logic [NLINK-1:0]           link_req;
	logic [DW-1:0]              tick_ctrl_reg;
	logic                       tick_flag_reg;
	logic [TICK_CW-1:0]         tick_cnt_reg;
	logic                       tick_pulse;
	logic                       tick_irq;
	logic [DW-1:0]              rdata_next;
	logic                       flag_rd;

	// module flags: OR of enabled leaves per function block
	for (genvar l = 0; l < NLINK; l++) begin : g_link
		for (genvar s = 0; s < NSRC; s++) begin : g_src
			logic mode_ok;
			// in-band and bit message detectors are absent in E1
			assign mode_ok = ((s == SRC_INBAND) || (s == SRC_BITMSG)) ? t1_mode_i[l] : 1'b1;
			assign mod_flag[l][s] = mode_ok && |(leaf_i[l].ind[s] & leaf_i[l].en[s]);
		end
		assign link_req[l] = |mod_flag[l];
	end

	// one-second divider producing a single-cycle enable
	always_ff @(posedge mclk_i) begin
		if (srst_i || tick_pulse) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
		end
	end
	assign tick_pulse = (tick_cnt_reg == TICK_CW'(TICK_DIV - 1));

	// sticky timer flag, cleared by reading it; a new tick wins over the clear
	assign flag_rd = req_i.rd && (req_i.addr == ADDR_TICK_FLAG);
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			tick_flag_reg <= 1'b0;
		end else if (tick_pulse) begin
			tick_flag_reg <= 1'b1;
		end else if (flag_rd) begin
			tick_flag_reg <= 1'b0;
		end
	end

	// timer interrupt enable, software writable
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			tick_ctrl_reg <= TICK_CTRL_RST;
		end else if (req_i.wr && (req_i.addr == ADDR_TICK_CTRL)) begin
			tick_ctrl_reg <= req_i.wdata;
		end
	end
	assign tick_irq = tick_flag_reg && tick_ctrl_reg[TICK_BIT];

	// read decode; unmapped addresses read zero
	always_comb begin
		rdata_next = '0;
		if (req_i.addr == ADDR_LINK_REQ) begin
			rdata_next[LINK_REQ_LSB +: NLINK] = link_req;
		end else if (req_i.addr == ADDR_TICK_CTRL) begin
			rdata_next = tick_ctrl_reg;
		end else if (req_i.addr == ADDR_TICK_FLAG) begin
			rdata_next[TICK_BIT] = tick_flag_reg;
		end else begin
			for (int l = 0; l < NLINK; l++) begin
				if (req_i.addr == ADDR_MOD_FRM + AW'(l) * LINK_STRIDE) begin
					rdata_next = mod_flag[l][SRC_MOD1_BASE-1:0];
				end else if (req_i.addr == ADDR_MOD_HDLC + AW'(l) * LINK_STRIDE) begin
					rdata_next = mod_flag[l][SRC_LINE-1:SRC_MOD1_BASE];
				end else if (req_i.addr == ADDR_MOD_LINE + AW'(l) * LINK_STRIDE) begin
					rdata_next[LINE_BIT] = mod_flag[l][SRC_LINE];
				end
			end
		end
	end

	// registered read data, updated only on a read strobe
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rdata_o <= '0;
		end else if (req_i.rd) begin
			rdata_o <= rdata_next;
		end
	end

	// combinational pin so release follows the last served source at once
	assign int_n_o = srst_i ? 1'b1 : ~(|link_req || tick_irq);
endmodule

// ---- verification/dlia_chk_sva.sv ----
// port checker for the interrupt aggregator
// assumes it is bound onto dlia_top
`timescale 1ns/100ps
module dlia_chk import dlia_pkg::*; (
	input wire logic             mclk_i,                  // clock
	input wire logic             srst_i,                  // reset
	input wire logic             int_n_o,                 // irq pin
	input wire logic [NLINK-1:0] t1_mode_i,               // mode
	input wire dlia_leaf_s       leaf_i [NLINK],          // leaves
	input wire dlia_req_s        req_i,                   // access
	input wire logic [DW-1:0]    rdata_o);                // read data
	logic [NLINK-1:0][NSRC-1:0] m;
	logic [1:0]                 lk;
	logic                       te;
	// expected module flags; e1 hides sources 6 and 7
	always_comb for (int l = 0; l < NLINK; l++) begin
		for (int s = 0; s < NSRC; s++) m[l][s] = |(leaf_i[l].ind[s] & leaf_i[l].en[s])
			&& (t1_mode_i[l] || (s != SRC_BITMSG && s != SRC_INBAND));
		lk[l] = |m[l];
	end
	// shadow of the timer enable, flag itself is unseen
	always_ff @(posedge mclk_i) begin
		if (srst_i) te <= 1'b0;
		else if (req_i.wr && req_i.addr == ADDR_TICK_CTRL) te <= req_i.wdata[TICK_BIT];
	end
	// request passed in, so the assertions see its sampled value
	function automatic logic rda(dlia_req_s r, logic [AW-1:0] a);
		return r.rd && r.addr == a;
	endfunction
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	a_irq_low: assert property (|lk |-> !int_n_o) else $error("irq not low");
	a_link_field: assert property (rda(req_i, ADDR_LINK_REQ)
		|=> rdata_o[2:1] == $past(lk)) else $error("link bits");
	a_frm_flags: assert property (rda(req_i, ADDR_MOD_FRM)
		|=> rdata_o == $past(m[0][7:0])) else $error("frm");
	a_hdlc_flags: assert property (rda(req_i, ADDR_MOD_HDLC)
		|=> rdata_o == $past(m[0][15:8])) else $error("hdlc");
	a_line_flag: assert property (rda(req_i, ADDR_MOD_LINE)
		|=> rdata_o[0] == $past(m[0][16])) else $error("line unit");
	a_link1_flags: assert property (rda(req_i, ADDR_MOD_FRM + LINK_STRIDE)
		|=> rdata_o == $past(m[1][7:0])) else $error("l1");
	a_tick_gate: assert property (!lk && !te |-> int_n_o) else $error("tick gate");
	a_ctrl_echo: assert property (req_i.wr && req_i.addr == ADDR_TICK_CTRL ##1 !req_i.wr
		##1 rda(req_i, ADDR_TICK_CTRL) && !req_i.wr |=> rdata_o == $past(req_i.wdata, 3)) else $error("ctrl");
	c_irq: cover property (!int_n_o);
	c_tick: cover property (!lk && !int_n_o);
	c_flag: cover property (rda(req_i, ADDR_TICK_FLAG));
endmodule
bind dlia_top dlia_chk dlia_chk_i (.mclk_i, .srst_i, .int_n_o, .t1_mode_i, .leaf_i, .req_i, .rdata_o);

// ---- verification/dlia_host.sv ----
// host model driving the register strobe port
// assumes rdata_o settles after the taking edge
`timescale 1ns/100ps
module dlia_host import dlia_pkg::*; (
	input  wire logic          mclk_i,  // clock
	input  wire logic [DW-1:0] rdata_o, // read data
	output dlia_req_s          req_o);  // request
	initial req_o = '0;
	// hold one cycle; an idle cycle between accesses avoids double drive
	task automatic acc(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d, output logic [DW-1:0] q);
		@(posedge mclk_i) req_o <= {!w, w, a, d};
		@(posedge mclk_i) req_o <= '0;
		#1 q = rdata_o;
	endtask
endmodule

// ---- verification/test_dual_link_interrupt_aggregator.sv ----
// bench: leaf, mode, reset and timer tests via the host model
// assumes the host model owns the register port and the checker is bound onto the design
`timescale 1ns/100ps
module test_dual_link_interrupt_aggregator import dlia_pkg::*;;
	logic             mclk_i = 0, srst_i = 1, int_n;
	logic [NLINK-1:0] t1_mode_i = '1;
	dlia_leaf_s       leaf_i [NLINK] = '{default: '0};
	dlia_req_s        req;
	logic [DW-1:0]    rdata, q;
	int               failures = 0, samples_checked = 0, cyc = 0;
	always #5 mclk_i = ~mclk_i;
	dlia_top #(.TICK_DIV(20)) dlia_top_i (.mclk_i, .srst_i, .leaf_i, .t1_mode_i, .req_i(req), .rdata_o(rdata), .int_n_o(int_n));
	dlia_host dlia_host_i (.mclk_i, .rdata_o(rdata), .req_o(req));
	task automatic chk(string n, logic [DW-1:0] e, logic [DW-1:0] s);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rd(logic [AW-1:0] a, logic [DW-1:0] e);
		dlia_host_i.acc(0, a, 0, q);
		chk("reg", e, q);
	endtask
	task automatic wrap_up;
		$display("checked %0d failed %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// hang guard
	always @(posedge mclk_i) if (++cyc == 20000) begin
		failures++;
		wrap_up;
	end
	initial begin
		repeat (5) @(posedge mclk_i);
		srst_i <= 0;
		rd(ADDR_LINK_REQ, 8'h00);
		for (int l = 0; l < 2; l++) for (int s = 0; s < NSRC; s++) begin
			@(posedge mclk_i) leaf_i[l].ind[s] <= 8'h10;
			@(posedge mclk_i) #1 chk("masked", 1, int_n);
			@(posedge mclk_i) leaf_i[l].en[s] <= 8'h10;
			@(posedge mclk_i) #1 chk("int_n", 0, int_n);
			rd(ADDR_LINK_REQ, 8'h02 << l);
			rd((s == 16 ? ADDR_MOD_LINE : s < 8 ? ADDR_MOD_FRM : ADDR_MOD_HDLC) + (l ? LINK_STRIDE : 9'h0),
				s == 16 ? 8'h01 : 8'h01 << (s % 8));
			@(posedge mclk_i) leaf_i[l] <= '0;
		end
		$display("leaf test done");
		@(posedge mclk_i) t1_mode_i <= 2'b10;
		leaf_i[0].ind[7] <= 8'h01;
		leaf_i[0].en[7] <= 8'h01;
		@(posedge mclk_i) #1 chk("e1", 1, int_n);
		rd(ADDR_MOD_FRM, 8'h00);
		@(posedge mclk_i) t1_mode_i <= 2'b11;
		@(posedge mclk_i) #1 chk("t1", 0, int_n);
		@(posedge mclk_i) leaf_i[0] <= '0;
		$display("mode test done");
		dlia_host_i.acc(1, ADDR_TICK_CTRL, 8'h81, q);
		chk("tick on", 0, int_n);
		rd(ADDR_TICK_CTRL, 8'h81);
		// mid-run reset restarts the divider, so ticks land at known edges 25, 45 after it
		@(posedge mclk_i) srst_i <= 1;
		repeat (4) @(posedge mclk_i);
		#1 chk("int_n in reset", 1, int_n);
		chk("rdata after reset", 8'h00, rdata);
		@(posedge mclk_i) srst_i <= 0;
		rd(ADDR_TICK_CTRL, 8'h00);
		dlia_host_i.acc(1, ADDR_TICK_CTRL, 8'h01, q);
		rd(ADDR_TICK_CTRL, 8'h01);
		chk("flag gate", 1, int_n);
		rd(ADDR_TICK_FLAG, 8'h00);
		repeat (16) @(posedge mclk_i);
		#1 chk("tick", 0, int_n);
		rd(ADDR_TICK_FLAG, 8'h01);
		rd(ADDR_TICK_FLAG, 8'h00);
		chk("flag cleared", 1, int_n);
		// this read is taken on the tick edge itself; the new tick must survive it
		repeat (10) @(posedge mclk_i);
		rd(ADDR_TICK_FLAG, 8'h00);
		chk("set wins", 0, int_n);
		dlia_host_i.acc(1, ADDR_TICK_CTRL, 8'h00, q);
		chk("tick off", 1, int_n);
		rd(ADDR_TICK_FLAG, 8'h01);
		rd(9'h1ff, 8'h00);
		$display("timer test done");
		wrap_up;
	end
endmodule
